// ### fws_pkg.sv
// package for the fault and warning supervisor: status bit positions and timing
package fws_pkg;
  // ****************************************
  // status word 0x1 bit positions (warnings and flags)
  // ****************************************
  localparam int unsigned FWS_STAT1_ADDR = 1;
  localparam int unsigned FWS_S1_OTW = 0;
  localparam int unsigned FWS_S1_TF3 = 1;
  localparam int unsigned FWS_S1_TF2 = 2;
  localparam int unsigned FWS_S1_TF1 = 3;
  localparam int unsigned FWS_S1_OV = 6;
  localparam int unsigned FWS_S1_UVFL = 7;
  localparam int unsigned FWS_S1_TF4 = 8;
  // ****************************************
  // status word 0x3 bit positions (latched faults)
  // ****************************************
  localparam int unsigned FWS_STAT3_ADDR = 3;
  localparam int unsigned FWS_S3_PREL = 0;
  localparam int unsigned FWS_S3_PABS = 1;
  localparam int unsigned FWS_S3_PUV = 2;
  localparam int unsigned FWS_S3_LSUV = 4;
  localparam int unsigned FWS_S3_OVERTEMP_SHUTDOWN = 8;
  localparam int unsigned FWS_S3_GUV = 10;
  // ****************************************
  // control word 0x9 bit positions
  // ****************************************
  localparam int unsigned FWS_CTRL9_ADDR = 9;
  localparam int unsigned FWS_C9_CLR = 1;
  localparam int unsigned FWS_C9_LKDIS = 9;
  localparam logic [10:0] FWS_STAT_RST = 11'h000;
  // ****************************************
  // timing: gate-enable low pulse at least 1 us
  // ****************************************
  localparam int unsigned FWS_CLK_MHZ = 200;
  localparam int unsigned FWS_EN_LOW_NS = 1000;
  localparam int unsigned FWS_EN_LOW_CYC = (FWS_EN_LOW_NS * FWS_CLK_MHZ + 999) / 1000;
  localparam int unsigned FWS_CNT_W = 8;

  // raw monitor levels from analog comparators
  typedef struct packed {
    logic main_supply_low_warning;
    logic main_supply_high_warning;
    logic gate_driver_supply_lockout;
    logic regulator_supply_lockout;
    logic high_pump_relative_overvoltage;
    logic high_pump_absolute_overvoltage;
    logic high_pump_undervoltage;
    logic low_side_supply_undervoltage;
    logic temp_flag_level_one;
    logic temp_flag_level_two;
    logic temp_flag_level_three;
    logic temp_flag_level_four;
    logic overtemp_warning;
    logic overtemp_shutdown;
  } fws_mon_t;

  // gate and supply controls that the supervisor decides
  typedef struct packed {
    logic gate_pull_low;
    logic gate_supply_en;
    logic logic_en;
  } fws_drive_t;
endpackage

// ### fws_supervisor.sv
// fault and warning supervisor: classifies monitor events, latches faults, drives fault pin
// Contract
// - main supply low warning is report-only, shown on fault pin and status1 bit 7.
// - main supply high warning is report-only, shown on fault pin and status1 bit 6.
// - main supply warnings never change operation nor shut the gate driver down.
// - gate supply lockout shuts gates, latches fault pin and status3 bit 10.
// - lockout-disable bit suppresses lockout action but status bit still sets.
// - regulator lockout is separate; below it gates low, supplies and logic off, silent.
// - pump relative and absolute overvoltage are latched faults, status3 bits 0 and 1.
// - pump undervoltage shuts gates, latches fault pin and status3 bit 2.
// - low-side supply undervoltage shuts gates, latches fault pin and status3 bit 4.
// - pump and low-side undervoltage protection cannot be disabled while operating.
// - temp flags one, two, three are live bits 3, 2, 1 without fault pin.
// - temp flag four is live status1 bit 8 without fault pin.
// - overtemp warning shows on fault pin and live status1 bit 0; gates continue.
// - overtemp shutdown latches, pulls gates low, disables supplies, sets status3 bit 8.
// - during overtemp shutdown serial access and register settings stay intact.
// - overtemp fault clears only once temperature is low and clear is issued.
// - each event class sets gate outputs, gate supplies and logic per its class.
// - latched fault holds until condition gone and clear bit or enable pulse.
// - clear bit returns to zero once faults reset and fault pin released.
// - a fault during a warning takes precedence, latches pin and shuts gates.
`timescale 1ns/1ps
`default_nettype none
module fws_supervisor
  import fws_pkg::*;
#(
  parameter int unsigned EN_LOW_CYC = FWS_EN_LOW_CYC
) (
  input wire logic MCLK,
  input wire logic RST_B,
  input wire fws_mon_t MON,
  input wire logic GATE_EN,
  input wire logic CLEAR_FAULTS_SET,
  input wire logic GATE_LOCKOUT_DISABLE,
  output logic CLEAR_FAULTS_BIT,
  output logic [10:0] STATUS_WARN,
  output logic [10:0] STATUS_FAULT,
  output logic FAULT_PIN_ACTIVE_LOW_O,
  output logic FAULT_PIN_ACTIVE_LOW_OE,
  output logic OPERATING,
  output fws_drive_t DRIVE
);
  // ****************************************
  // input synchronisers: three stages, change accepted when stages two and three agree
  // ****************************************
  localparam int unsigned NIN = $bits(fws_mon_t) + 1;
  logic [NIN-1:0] raw_in;
  logic [NIN-1:0] s1_q;
  logic [NIN-1:0] s2_q;
  logic [NIN-1:0] s3_q;
  logic [NIN-1:0] flt_q;
  fws_mon_t mon;
  logic en_s;
  logic [FWS_CNT_W-1:0] low_cnt_q;
  logic en_low_ok_q;
  logic en_pulse;
  logic clr_req;
  logic lockout_disable_q;
  logic clr_pend_q;
  logic [10:0] fault_d;
  logic [10:0] fault_q;
  logic [10:0] cond;
  logic fault_any;
  logic warn_any;
  logic op_q;

  assign raw_in = {MON, GATE_EN};

  // synchroniser chain; stage one feeds only stage two
  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= raw_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // per-bit agreement filter; holds last value while stages disagree
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++) begin : g_filt
      always_ff @(posedge MCLK) begin
        if (!RST_B) begin
          flt_q[gi] <= 1'b0;
        end else if (s2_q[gi] == s3_q[gi]) begin
          flt_q[gi] <= s3_q[gi];
        end
      end
    end
  endgenerate

  assign mon = fws_mon_t'(flt_q[NIN-1:1]);
  assign en_s = flt_q[0];

  // ****************************************
  // gate-enable reset pulse: low phase of at least EN_LOW_CYC then high again
  // ****************************************
  // counter saturates so a long low phase still qualifies
  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      low_cnt_q <= '0;
      en_low_ok_q <= 1'b0;
    end else if (!en_s) begin
      if (low_cnt_q != {FWS_CNT_W{1'b1}}) begin
        low_cnt_q <= low_cnt_q + 1'b1;
      end
      en_low_ok_q <= (32'(low_cnt_q) + 32'h1 >= EN_LOW_CYC);
    end else begin
      low_cnt_q <= '0;
      en_low_ok_q <= 1'b0;
    end
  end

  assign en_pulse = en_s && en_low_ok_q;

  // operating state: enable high and no latched fault other than a lockout bit under lockout-disable; a fault drops back to standby
  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      op_q <= 1'b0;
    end else begin
      op_q <= en_s && !fault_any && !fault_d[FWS_S3_OVERTEMP_SHUTDOWN];
    end
  end

  // lockout-disable acts in any state; pump and low-side undervoltage have no
  // disable input at all, so their protection can never be switched off
  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      lockout_disable_q <= 1'b0;
    end else begin
      lockout_disable_q <= GATE_LOCKOUT_DISABLE;
    end
  end

  // ****************************************
  // latched fault status
  // ****************************************
  always_comb begin
    cond = '0;
    cond[FWS_S3_PREL] = mon.high_pump_relative_overvoltage;
    cond[FWS_S3_PABS] = mon.high_pump_absolute_overvoltage;
    cond[FWS_S3_PUV] = mon.high_pump_undervoltage;
    cond[FWS_S3_LSUV] = mon.low_side_supply_undervoltage;
    cond[FWS_S3_OVERTEMP_SHUTDOWN] = mon.overtemp_shutdown;
    cond[FWS_S3_GUV] = mon.gate_driver_supply_lockout;
  end

  assign clr_req = clr_pend_q || en_pulse;

  // a bit clears only when its condition is gone; a new condition always wins
  always_comb begin
    fault_d = fault_q | cond;
    if (clr_req) begin
      fault_d = cond;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      fault_q <= FWS_STAT_RST;
    end else begin
      fault_q <= fault_d;
    end
  end

  // clear bit self-clears once faults are gone and the pin released
  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      clr_pend_q <= 1'b0;
    end else if (CLEAR_FAULTS_SET) begin
      clr_pend_q <= 1'b1;
    end else if (clr_pend_q && fault_d == '0 && !warn_any) begin
      clr_pend_q <= 1'b0;
    end
  end

  // lockout bit is reported but only acts on gates when not disabled
  assign fault_any = (fault_q[FWS_S3_PREL] || fault_q[FWS_S3_PABS] || fault_q[FWS_S3_PUV] ||
                      fault_q[FWS_S3_LSUV] || fault_q[FWS_S3_OVERTEMP_SHUTDOWN]) ||
                     (fault_q[FWS_S3_GUV] && !lockout_disable_q);

  // warnings only indicate, while present
  assign warn_any = mon.main_supply_low_warning || mon.main_supply_high_warning ||
                    mon.overtemp_warning;

  // ****************************************
  // outputs
  // ****************************************
  // status words from flops; serial side is untouched by shutdown
  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      STATUS_WARN <= FWS_STAT_RST;
      STATUS_FAULT <= FWS_STAT_RST;
      CLEAR_FAULTS_BIT <= 1'b0;
      OPERATING <= 1'b0;
    end else begin
      STATUS_WARN <= '0;
      STATUS_WARN[FWS_S1_UVFL] <= mon.main_supply_low_warning;
      STATUS_WARN[FWS_S1_OV] <= mon.main_supply_high_warning;
      STATUS_WARN[FWS_S1_TF1] <= mon.temp_flag_level_one;
      STATUS_WARN[FWS_S1_TF2] <= mon.temp_flag_level_two;
      STATUS_WARN[FWS_S1_TF3] <= mon.temp_flag_level_three;
      STATUS_WARN[FWS_S1_TF4] <= mon.temp_flag_level_four;
      STATUS_WARN[FWS_S1_OTW] <= mon.overtemp_warning;
      STATUS_FAULT <= fault_d;
      CLEAR_FAULTS_BIT <= clr_pend_q || CLEAR_FAULTS_SET;
      OPERATING <= op_q;
    end
  end

  // open-drain pin: oe low means pulling low; fault takes precedence over warnings
  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      FAULT_PIN_ACTIVE_LOW_O <= 1'b0;
      FAULT_PIN_ACTIVE_LOW_OE <= 1'b1;
    end else begin
      FAULT_PIN_ACTIVE_LOW_O <= 1'b0;
      FAULT_PIN_ACTIVE_LOW_OE <= !((fault_d != '0) || warn_any);
    end
  end

  // gate drive class decision; regulator lockout overrides everything silently
  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      DRIVE <= '{gate_pull_low: 1'b1, gate_supply_en: 1'b0, logic_en: 1'b0};
    end else if (mon.regulator_supply_lockout) begin
      DRIVE <= '{gate_pull_low: 1'b1, gate_supply_en: 1'b0, logic_en: 1'b0};
    end else begin
      DRIVE.logic_en <= 1'b1;
      DRIVE.gate_pull_low <= fault_any || !op_q;
      DRIVE.gate_supply_en <= !fault_any && en_s;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_warn_no_shut;
    @(posedge MCLK) disable iff (!RST_B)
      (warn_any && !fault_any && op_q && !mon.regulator_supply_lockout) |=> !DRIVE.gate_pull_low;
  endproperty
  a_warn_no_shut: assert property (p_warn_no_shut) else $error("warning shut gates");

  property p_pump_uv;
    @(posedge MCLK) disable iff (!RST_B)
      mon.high_pump_undervoltage |=> STATUS_FAULT[FWS_S3_PUV] && !FAULT_PIN_ACTIVE_LOW_OE;
  endproperty
  a_pump_uv: assert property (p_pump_uv) else $error("pump uv not latched");

  property p_ls_uv;
    @(posedge MCLK) disable iff (!RST_B)
      mon.low_side_supply_undervoltage |=> ##1 DRIVE.gate_pull_low;
  endproperty
  a_ls_uv: assert property (p_ls_uv) else $error("ls uv did not pull gates");

  property p_lockout_dis;
    @(posedge MCLK) disable iff (!RST_B)
      mon.gate_driver_supply_lockout |=> STATUS_FAULT[FWS_S3_GUV];
  endproperty
  a_lockout_dis: assert property (p_lockout_dis) else $error("lockout bit missing");

  property p_overtemp_shutdown_hold;
    @(posedge MCLK) disable iff (!RST_B)
      (fault_q[FWS_S3_OVERTEMP_SHUTDOWN] && !clr_req) |=> fault_q[FWS_S3_OVERTEMP_SHUTDOWN];
  endproperty
  a_overtemp_shutdown_hold: assert property (p_overtemp_shutdown_hold) else $error("overtemp_shutdown dropped without clear");

  property p_tf4;
    @(posedge MCLK) disable iff (!RST_B)
      $rose(mon.temp_flag_level_four) |=> STATUS_WARN[FWS_S1_TF4];
  endproperty
  a_tf4: assert property (p_tf4) else $error("temp flag four missing");

  property p_reg_lock;
    @(posedge MCLK) disable iff (!RST_B)
      mon.regulator_supply_lockout |=> !DRIVE.logic_en && !DRIVE.gate_supply_en;
  endproperty
  a_reg_lock: assert property (p_reg_lock) else $error("regulator lockout not applied");

  property p_warn_release;
    @(posedge MCLK) disable iff (!RST_B)
      (!warn_any && fault_d == '0) |=> FAULT_PIN_ACTIVE_LOW_OE;
  endproperty
  a_warn_release: assert property (p_warn_release) else $error("pin not released");

  // a held fault keeps the pin asserted whatever the warnings do
  property p_fault_pin;
    @(posedge MCLK) disable iff (!RST_B)
      (fault_q != '0 && !clr_req) |=> !FAULT_PIN_ACTIVE_LOW_OE;
  endproperty
  a_fault_pin: assert property (p_fault_pin) else $error("latched fault released pin");

  // fault class: gates pulled low, gate supplies off, logic still running
  property p_fault_gates;
    @(posedge MCLK) disable iff (!RST_B)
      (fault_any && !mon.regulator_supply_lockout) |=>
        DRIVE.gate_pull_low && !DRIVE.gate_supply_en && DRIVE.logic_en;
  endproperty
  a_fault_gates: assert property (p_fault_gates) else $error("fault class drive wrong");

  // pending clear drops once nothing is latched and the pin is free
  property p_clr_self;
    @(posedge MCLK) disable iff (!RST_B)
      (clr_pend_q && !CLEAR_FAULTS_SET && fault_d == '0 && !warn_any) |=> !clr_pend_q;
  endproperty
  a_clr_self: assert property (p_clr_self) else $error("clear bit stuck");
endmodule
`default_nettype wire

// ### fws_mcu_model.sv
// external controller model: drives gate enable and the clear-faults request
`timescale 1ns/1ps
`default_nettype none
module fws_mcu_model #(
  parameter int unsigned LOW_CYC = 4
) (
  input wire logic MCLK,
  output var logic GATE_EN,
  output var logic CLEAR_FAULTS_SET
);
  // ****************************************
  // controller actions
  // ****************************************
  // enable sits high so the driver can reach its operating state
  initial begin
    GATE_EN = 1'b1;
    CLEAR_FAULTS_SET = 1'b0;
  end
  // one-cycle write of the clear bit, launched just after an edge
  task automatic clear_faults();
    @(posedge MCLK);
    #1 CLEAR_FAULTS_SET = 1'b1;
    @(posedge MCLK);
    #1 CLEAR_FAULTS_SET = 1'b0;
  endtask
  // high-low-high pulse; two spare cycles cover synchroniser slip
  task automatic enable_pulse();
    @(posedge MCLK);
    #1 GATE_EN = 1'b0;
    repeat (LOW_CYC + 2) @(posedge MCLK);
    #1 GATE_EN = 1'b1;
  endtask
endmodule
`default_nettype wire

// ### tb.sv
// self-checking testbench for the fault and warning supervisor
`timescale 1ns/1ps
`default_nettype none
module tb;
  import fws_pkg::*;
  localparam int unsigned LOW_CYC = 4;
  typedef struct packed {
    logic [13:0] mon;
    logic [10:0] warn;
    logic pin;
    logic [2:0] drv;
  } fws_row_t;
  logic MCLK, RST_B, GATE_EN, CLEAR_FAULTS_SET, GATE_LOCKOUT_DISABLE;
  logic CLEAR_FAULTS_BIT, FAULT_PIN_ACTIVE_LOW_O, FAULT_PIN_ACTIVE_LOW_OE, OPERATING;
  logic [10:0] STATUS_WARN, STATUS_FAULT;
  fws_mon_t MON;
  fws_drive_t DRIVE;
  int err_total;
  int num_checks;
  // open-drain pin with pull-up: released reads high
  wire logic pin_lvl = FAULT_PIN_ACTIVE_LOW_OE ? 1'b1 : FAULT_PIN_ACTIVE_LOW_O;
  // ****************************************
  // live events: monitor input, status word, pin, drive
  // ****************************************
  fws_row_t rows [10] = '{
    '{14'h2000, 11'h080, 1'b0, 3'b011}, '{14'h1000, 11'h040, 1'b0, 3'b011},
    '{14'h0020, 11'h008, 1'b1, 3'b011}, '{14'h0010, 11'h004, 1'b1, 3'b011},
    '{14'h0008, 11'h002, 1'b1, 3'b011}, '{14'h0004, 11'h100, 1'b1, 3'b011},
    '{14'h0002, 11'h001, 1'b0, 3'b011}, '{14'h0000, 11'h000, 1'b1, 3'b011},
    '{14'h0400, 11'h000, 1'b1, 3'b100}, '{14'h0000, 11'h000, 1'b1, 3'b011}};
  // latched faults and their status bit
  logic [13:0] flt_mon [6] = '{14'h0200, 14'h0100, 14'h0080, 14'h0040, 14'h0001, 14'h0800};
  int flt_bit [6] = '{FWS_S3_PREL, FWS_S3_PABS, FWS_S3_PUV, FWS_S3_LSUV, FWS_S3_OVERTEMP_SHUTDOWN, FWS_S3_GUV};

  fws_supervisor #(.EN_LOW_CYC(LOW_CYC)) dut_u (
    .MCLK(MCLK), .RST_B(RST_B), .MON(MON), .GATE_EN(GATE_EN),
    .CLEAR_FAULTS_SET(CLEAR_FAULTS_SET), .GATE_LOCKOUT_DISABLE(GATE_LOCKOUT_DISABLE),
    .CLEAR_FAULTS_BIT(CLEAR_FAULTS_BIT), .STATUS_WARN(STATUS_WARN), .STATUS_FAULT(STATUS_FAULT),
    .FAULT_PIN_ACTIVE_LOW_O(FAULT_PIN_ACTIVE_LOW_O), .FAULT_PIN_ACTIVE_LOW_OE(FAULT_PIN_ACTIVE_LOW_OE),
    .OPERATING(OPERATING), .DRIVE(DRIVE));
  fws_mcu_model #(.LOW_CYC(LOW_CYC)) mcu_u (
    .MCLK(MCLK), .GATE_EN(GATE_EN), .CLEAR_FAULTS_SET(CLEAR_FAULTS_SET));

  // 200 MHz clock
  initial begin
    MCLK = 1'b0;
    forever #2.5 MCLK = ~MCLK;
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  // eight cycles clear the synchroniser plus the registered answer
  task automatic settle();
    repeat (8) @(posedge MCLK);
    #1;
  endtask
  task automatic look(input logic [10:0] fe, input logic pn, input logic [2:0] dv);
    chk("status_fault", 16'(STATUS_FAULT), 16'(fe));
    chk("fault_pin", 16'(pin_lvl), 16'(pn));
    chk("drive", 16'(DRIVE), 16'(dv));
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    int n;
    RST_B = 1'b0;
    MON = '0;
    GATE_LOCKOUT_DISABLE = 1'b0;
    err_total = 0;
    num_checks = 0;
    repeat (2) @(posedge MCLK);
    #1;
    look(11'h000, 1'b1, 3'b100);
    chk("operating", 16'(OPERATING), 16'h0000);
    chk("status_warn", 16'(STATUS_WARN), 16'h0000);
    RST_B = 1'b1;
    settle();
    // warnings and flags follow their condition with no clear
    foreach (rows[i]) begin
      MON = rows[i].mon;
      settle();
      chk("status_warn", 16'(STATUS_WARN), 16'(rows[i].warn));
      look(11'h000, rows[i].pin, rows[i].drv);
    end
    // each fault latches; clears alternate between clear bit and enable pulse
    foreach (flt_mon[i]) begin
      MON = flt_mon[i];
      settle();
      look(11'(1 << flt_bit[i]), 1'b0, 3'b101);
      MON = '0;
      settle();
      look(11'(1 << flt_bit[i]), 1'b0, 3'b101);
      if (i % 2 == 0) begin
        mcu_u.clear_faults();
      end else begin
        mcu_u.enable_pulse();
      end
      settle();
      look(11'h000, 1'b1, 3'b011);
      chk("clear_bit", 16'(CLEAR_FAULTS_BIT), 16'h0000);
      chk("operating", 16'(OPERATING), 16'h0001);
    end
    // shutdown during a warning; clear while still hot must not take
    MON = 14'h2001;
    settle();
    chk("status_warn", 16'(STATUS_WARN), 16'h0080);
    look(11'h100, 1'b0, 3'b101);
    mcu_u.clear_faults();
    settle();
    look(11'h100, 1'b0, 3'b101);
    chk("clear_bit", 16'(CLEAR_FAULTS_BIT), 16'h0001);
    MON = '0;
    n = 0;
    while (CLEAR_FAULTS_BIT !== 1'b0 && n < 40) begin
      @(posedge MCLK);
      #1;
      n++;
    end
    chk("clear_wait", 16'(n == 40), 16'h0000);
    settle();
    look(11'h000, 1'b1, 3'b011);
    // lockout disable keeps the gates but not the status; pump guard stays on
    GATE_LOCKOUT_DISABLE = 1'b1;
    MON = 14'h0800;
    settle();
    chk("status_fault", 16'(STATUS_FAULT), 16'h0400);
    chk("drive", 16'(DRIVE), 16'h0003);
    MON = 14'h0880;
    settle();
    chk("drive", 16'(DRIVE), 16'h0005);
    MON = '0;
    mcu_u.clear_faults();
    settle();
    chk("status_fault", 16'(STATUS_FAULT), 16'h0000);
    // reset in mid-run drops a latched fault; the driver then comes back up
    MON = 14'h0040;
    settle();
    RST_B = 1'b0;
    repeat (2) @(posedge MCLK);
    #1;
    look(11'h000, 1'b1, 3'b100);
    RST_B = 1'b1;
    MON = '0;
    settle();
    look(11'h000, 1'b1, 3'b011);
    tally_and_finish();
  end
endmodule
`default_nettype wire
